// File: verilog/ir_carrier_generator.sv
// Carrier generator and output stage of the infrared transmitter
//
// What this block does
// R1: Times carrier phases in oscillator periods, up to 63 counts per phase.
// R2: Holds primary and secondary count sets; time mode uses only primary.
// R3: In shift-keying mode, modulator requests swap count sets without software.
// R4: Baseband select holds the carrier to the modulator continuously high.
// R5: Counting runs only with module enable set and baseband select clear.
// R6: Six-bit up counter compares after each increment with selected count.
// R7: On match the counter clears and compare moves to the other count.
// R8: High match drives carrier low; low match drives it high again.
// R9: Carrier frequency is oscillator over high plus low counts, each 1..63.
// R10: Prescale halve control bit 6 halves the carrier frequency.
// R11: Duty cycle is high count over high plus low counts.
// R12: Enabled, the modulator drives the pin; otherwise the output latch does.
// R13: Output latch is read and written through bit 7 of primary count registers.
// R14: Latch writes land on either bus clock edge, one oscillator period apart.
// R15: Gives the modulator a carrier and accepts a set-switch request.
// R16: Primary high write lands on falling edge, primary low on rising edge.
// R17: Reset clears the latch; count values survive reset.
// R18: Software loads nonzero counts before enabling the generator.
// R19: Count set switches only at a carrier period boundary or while counting is stopped.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ns
module ir_carrier_generator (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Modulator side
	input wire logic fsk_switch,
	input wire logic modulator_out,
	output logic carrier_out,
	output logic carrier_period_end,
	output ir_carrier_pkg::ctl_t modulator_control_status,
	// Infrared pin
	output logic ir_out_pin
);
	import ir_carrier_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ctl_t ctl_q, ctl_d;
	count_pair_t pri_q, pri_d, sec_q, sec_d, sel_counts;
	logic latch_q, latch_d;
	logic pend_q, pend_d, pend_val_q, pend_val_d, pend_rise_q, pend_rise_d;
	logic bus_phase_q, bus_phase_d;
	logic div_q, div_d, tick_q, tick_d;
	logic sec_sel_q, sec_sel_d, switch_pend_q, switch_pend_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic carrier_q, carrier_d, end_q, end_d, pin_q, pin_d;
	logic run, wr_en, setup, mapped;
	logic tmr_carrier, tmr_end;

	assign run = ctl_q.module_enable && !ctl_q.baseband_select; // see R5
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
	assign mapped = (paddr == ADDR_PRI_HIGH) || (paddr == ADDR_PRI_LOW) ||
		(paddr == ADDR_SEC_HIGH) || (paddr == ADDR_SEC_LOW) || (paddr == ADDR_CONTROL);

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	always_comb begin
		pready_d = setup;
		pslverr_d = setup && !mapped;
		prdata_d = 32'h00000000;
		if (setup && !pwrite) begin
			case (paddr)
				ADDR_PRI_HIGH: prdata_d = {24'h000000, latch_q, 1'b0, pri_q.high}; // see R13
				ADDR_PRI_LOW: prdata_d = {24'h000000, latch_q, 1'b0, pri_q.low}; // see R13
				ADDR_SEC_HIGH: prdata_d = {26'h0000000, sec_q.high};
				ADDR_SEC_LOW: prdata_d = {26'h0000000, sec_q.low};
				ADDR_CONTROL: prdata_d = {25'h0000000, ctl_q.prescale_halve,
					tmr_carrier, sec_sel_q, 1'b0, ctl_q.fsk_mode,
					ctl_q.baseband_select, ctl_q.module_enable};
				default: prdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// ----------------------------------------
	// Count registers
	// ----------------------------------------
	// No reset: software expects counts to survive reset
	always_comb begin
		pri_d = pri_q;
		sec_d = sec_q;
		if (wr_en) begin
			case (paddr)
				ADDR_PRI_HIGH: pri_d.high = pwdata[CNT_W-1:0];
				ADDR_PRI_LOW: pri_d.low = pwdata[CNT_W-1:0];
				ADDR_SEC_HIGH: sec_d.high = pwdata[CNT_W-1:0];
				ADDR_SEC_LOW: sec_d.low = pwdata[CNT_W-1:0];
				default: begin
					pri_d = pri_q;
					sec_d = sec_q;
				end
			endcase
		end
	end

	always_ff @(posedge pclk) begin // see R17
		pri_q <= pri_d;
		sec_q <= sec_d;
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_comb begin
		ctl_d = ctl_q;
		if (wr_en && (paddr == ADDR_CONTROL)) begin
			ctl_d.module_enable = pwdata[CTL_EN_BIT];
			ctl_d.baseband_select = pwdata[CTL_BASEBAND_SELECT_BIT];
			ctl_d.fsk_mode = pwdata[CTL_FSK_BIT];
			ctl_d.prescale_halve = pwdata[CTL_HALVE_BIT]; // see R10
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= CTL_RESET;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	// ----------------------------------------
	// Output latch
	// ----------------------------------------
	// Bus clock runs at half the oscillator; phase low marks its falling edge
	always_comb begin
		bus_phase_d = !bus_phase_q;
		latch_d = latch_q;
		pend_d = pend_q;
		pend_val_d = pend_val_q;
		pend_rise_d = pend_rise_q;
		if (pend_q && (bus_phase_q == pend_rise_q)) begin
			latch_d = pend_val_q; // see R14
			pend_d = 1'b0;
		end
		// A fresh write replaces any write still waiting for its edge
		if (wr_en && ((paddr == ADDR_PRI_HIGH) || (paddr == ADDR_PRI_LOW))) begin
			pend_d = 1'b1;
			pend_val_d = pwdata[LATCH_BIT]; // see R13
			pend_rise_d = (paddr == ADDR_PRI_LOW); // see R16
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_phase_q <= 1'b0;
			latch_q <= LATCH_RESET; // see R17
			pend_q <= 1'b0;
			pend_val_q <= 1'b0;
			pend_rise_q <= 1'b0;
		end else begin
			bus_phase_q <= bus_phase_d;
			latch_q <= latch_d;
			pend_q <= pend_d;
			pend_val_q <= pend_val_d;
			pend_rise_q <= pend_rise_d;
		end
	end

	// ----------------------------------------
	// Counting clock and set selection
	// ----------------------------------------
	always_comb begin
		div_d = run ? !div_q : 1'b0;
		tick_d = run && (!ctl_q.prescale_halve || div_q); // see R10
		// A request arriving with the boundary is kept, not lost
		switch_pend_d = switch_pend_q;
		sec_sel_d = sec_sel_q;
		if (tmr_end || !run) begin // see R19
			if (!ctl_q.fsk_mode) begin
				sec_sel_d = 1'b0; // see R2
				switch_pend_d = 1'b0;
			end else if (switch_pend_q) begin
				sec_sel_d = !sec_sel_q; // see R3
				switch_pend_d = 1'b0;
			end
		end
		if (fsk_switch && ctl_q.fsk_mode) begin
			switch_pend_d = 1'b1; // see R15
		end
		// New set must already govern the first tick of its period
		sel_counts = sec_sel_d ? sec_q : pri_q; // see R2, R19
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 1'b0;
			tick_q <= 1'b0;
			switch_pend_q <= 1'b0;
			sec_sel_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
			switch_pend_q <= switch_pend_d;
			sec_sel_q <= sec_sel_d;
		end
	end

	carrier_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.tick(tick_q),
		.counts(sel_counts),
		.carrier_q(tmr_carrier),
		.period_end_q(tmr_end),
		.cnt_q(),
		.phase_q()
	);

	// ----------------------------------------
	// Outputs to modulator and pin
	// ----------------------------------------
	always_comb begin
		carrier_d = ctl_q.baseband_select ? 1'b1 : tmr_carrier; // see R4
		end_d = tmr_end;
		pin_d = ctl_q.module_enable ? modulator_out : latch_q; // see R12
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carrier_q <= 1'b1;
			end_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			carrier_q <= carrier_d;
			end_q <= end_d;
			pin_q <= pin_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign carrier_out = carrier_q;
	assign carrier_period_end = end_q;
	assign modulator_control_status = ctl_q;
	assign ir_out_pin = pin_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_baseband_select_high: assert property ( // see R4
		ctl_q.baseband_select |=> carrier_out)
		else $error("baseband carrier not high");

	a_idle_no_tick: assert property ( // see R5
		!run |=> !tick_q ##1 !tick_q || run)
		else $error("tick while counting is disabled");

	a_halve_rate: assert property ( // see R10
		ctl_q.prescale_halve && $past(ctl_q.prescale_halve) && tick_q |=> !tick_q)
		else $error("halved rate ticked twice in a row");

	a_pin_select: assert property ( // see R12
		##1 ir_out_pin == ($past(ctl_q.module_enable) ? $past(modulator_out) : $past(latch_q)))
		else $error("pin source wrong");

	a_latch_edge: assert property ( // see R16
		latch_q != $past(latch_q) |-> $past(bus_phase_q) == $past(pend_rise_q) && $past(pend_q))
		else $error("latch changed off its edge");

	a_latch_lands: assert property ( // see R14
		wr_en && (paddr == ADDR_PRI_HIGH) |-> ##3 latch_q == $past(pwdata[LATCH_BIT], 3))
		else $error("latch write did not land");

	a_time_primary: assert property ( // see R2
		!ctl_q.fsk_mode && (tmr_end || !run) |=> !sec_sel_q)
		else $error("time mode left secondary set selected");

	a_switch_edge: assert property ( // see R19
		sec_sel_q != $past(sec_sel_q) |-> $past(tmr_end) || !$past(run))
		else $error("count set switched mid period");

	a_fsk_swap: assert property ( // see R3
		ctl_q.fsk_mode && switch_pend_q && tmr_end |=> sec_sel_q != $past(sec_sel_q))
		else $error("pending switch not applied at boundary");

	a_read_latch: assert property ( // see R13
		setup && !pwrite && (paddr == ADDR_PRI_LOW) |=> prdata[LATCH_BIT] == $past(latch_q))
		else $error("latch read back wrong");

endmodule : ir_carrier_generator

// File: verilog/ir_carrier_pkg.sv
// Constants, types and register map of the infrared carrier generator
package ir_carrier_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	// One counting clock is one oscillator period
	localparam int TICK_NS = 50;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

	// ----------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------
	localparam logic [7:0] IDX_PRI_HIGH = 8'h10;
	localparam logic [7:0] IDX_PRI_LOW = 8'h11;
	localparam logic [7:0] IDX_SEC_HIGH = 8'h12;
	localparam logic [7:0] IDX_SEC_LOW = 8'h13;
	localparam logic [7:0] IDX_CONTROL = 8'h14;
	localparam logic [7:0] ADDR_PRI_HIGH = {IDX_PRI_HIGH[5:0], 2'h0};
	localparam logic [7:0] ADDR_PRI_LOW = {IDX_PRI_LOW[5:0], 2'h0};
	localparam logic [7:0] ADDR_SEC_HIGH = {IDX_SEC_HIGH[5:0], 2'h0};
	localparam logic [7:0] ADDR_SEC_LOW = {IDX_SEC_LOW[5:0], 2'h0};
	localparam logic [7:0] ADDR_CONTROL = {IDX_CONTROL[5:0], 2'h0};

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LATCH_BIT = 7;
	localparam int CTL_EN_BIT = 0;
	localparam int CTL_BASEBAND_SELECT_BIT = 1;
	localparam int CTL_FSK_BIT = 2;
	localparam int CTL_SEC_BIT = 4;
	localparam int CTL_CAR_BIT = 5;
	localparam int CTL_HALVE_BIT = 6;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic prescale_halve;
		logic fsk_mode;
		logic baseband_select;
		logic module_enable;
	} ctl_t;

	localparam ctl_t CTL_RESET = 4'h0;
	localparam logic LATCH_RESET = 1'b0;

	typedef struct packed {
		logic [CNT_W-1:0] high;
		logic [CNT_W-1:0] low;
	} count_pair_t;

	typedef enum logic [1:0] {
		PH_HIGH = 2'b01,
		PH_LOW = 2'b10
	} phase_t;

endpackage : ir_carrier_pkg

// File: verilog/carrier_timer.sv
// Six-bit phase counter that times carrier high and low phases
`timescale 1ns/1ns
module carrier_timer (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic tick,
	input ir_carrier_pkg::count_pair_t counts,
	// Carrier state
	output logic carrier_q,
	output logic period_end_q,
	output logic [ir_carrier_pkg::CNT_W-1:0] cnt_q,
	output ir_carrier_pkg::phase_t phase_q
);
	import ir_carrier_pkg::*;

	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] inc;
	logic [CNT_W-1:0] limit;
	logic carrier_d;
	logic period_end_d;
	phase_t phase_d;

	// ----------------------------------------
	// Counter and phase
	// ----------------------------------------
	always_comb begin
		inc = cnt_q + CNT_ONE; // see R6
		limit = (phase_q == PH_HIGH) ? counts.high : counts.low; // see R6
		cnt_d = cnt_q;
		phase_d = phase_q;
		carrier_d = carrier_q;
		period_end_d = 1'b0;
		if (!run) begin
			// Idle counter restarts cleanly with a full high phase
			cnt_d = CNT_ZERO; // see R5
			phase_d = PH_HIGH;
			carrier_d = 1'b1;
		end else if (tick) begin // see R1
			if (inc == limit) begin
				cnt_d = CNT_ZERO; // see R7
				case (phase_q)
					PH_HIGH: begin
						phase_d = PH_LOW; // see R7, R11
						carrier_d = 1'b0; // see R8
					end
					PH_LOW: begin
						phase_d = PH_HIGH;
						carrier_d = 1'b1; // see R8
						period_end_d = 1'b1; // see R9
					end
					default: begin
						phase_d = PH_HIGH;
						carrier_d = 1'b1;
					end
				endcase
			end else begin
				cnt_d = inc;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= CNT_ZERO;
			phase_q <= PH_HIGH;
			carrier_q <= 1'b1;
			period_end_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			phase_q <= phase_d;
			carrier_q <= carrier_d;
			period_end_q <= period_end_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_idle_clear: assert property (@(posedge pclk) disable iff (!presetn) // see R5
		!run |=> (cnt_q == CNT_ZERO) && carrier_q && (phase_q == PH_HIGH))
		else $error("idle counter not cleared");

	a_match_clear: assert property (@(posedge pclk) disable iff (!presetn) // see R7
		run && tick && (inc == limit) |=> (cnt_q == CNT_ZERO) && (phase_q != $past(phase_q)))
		else $error("match did not clear counter and swap compare");

	a_high_match: assert property (@(posedge pclk) disable iff (!presetn) // see R8
		run && tick && (inc == counts.high) && (phase_q == PH_HIGH) |=> !carrier_q)
		else $error("high match did not drive carrier low");

	a_low_match: assert property (@(posedge pclk) disable iff (!presetn) // see R8
		run && tick && (inc == counts.low) && (phase_q == PH_LOW) |=> carrier_q && period_end_q)
		else $error("low match did not drive carrier high");

endmodule : carrier_timer

// File: tb/ir_led_model.sv
// Behavioural infrared emitter that counts light flashes on the pin
`timescale 1ns/1ns
module ir_led_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin
	input wire logic ir_out_pin,
	// Observation
	output logic [15:0] flashes
);
	logic lit_q;
	// Only rising light edges count, so a held level is one flash
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lit_q <= 1'b0;
			flashes <= 16'h0000;
		end else begin
			lit_q <= ir_out_pin;
			if (ir_out_pin && !lit_q) begin
				flashes <= flashes + 16'h0001;
			end
		end
	end
endmodule : ir_led_model

// File: tb/ir_carrier_generator_tb.sv
// Self-checking bench of the infrared carrier generator
`timescale 1ns/1ns
module ir_carrier_generator_tb;
	import ir_carrier_pkg::*;
	typedef struct packed {logic halve; logic [5:0] hi; logic [5:0] lo;} row_t;
	localparam row_t ROWS [5] = '{'{1'b0, 6'h02, 6'h01}, '{1'b0, 6'h01, 6'h01},
		'{1'b0, 6'h3f, 6'h3f}, '{1'b1, 6'h05, 6'h03}, '{1'b0, 6'h01, 6'h04}};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, per, hic;
	logic pready, pslverr, err, fsk_switch = 1'b0, modulator_out = 1'b0;
	logic carrier_out, carrier_period_end, ir_out_pin;
	logic [15:0] flashes;
	ctl_t mcs;
	int failures = 0, compares = 0, bad, i;
	always #25 pclk = ~pclk;
	ir_carrier_generator u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fsk_switch(fsk_switch),
		.modulator_out(modulator_out), .carrier_out(carrier_out),
		.carrier_period_end(carrier_period_end), .modulator_control_status(mcs),
		.ir_out_pin(ir_out_pin));
	ir_led_model u_led (.pclk(pclk), .presetn(presetn), .ir_out_pin(ir_out_pin),
		.flashes(flashes));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task results;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Idle edge first, so psel is never assigned twice in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task setup(input logic [7:0] hi, input logic [7:0] lo, input logic [31:0] ctl);
		apb(1'b1, ADDR_CONTROL, 32'h0);
		apb(1'b1, ADDR_PRI_HIGH, {24'h0, hi});
		apb(1'b1, ADDR_PRI_LOW, {24'h0, lo});
		apb(1'b1, ADDR_CONTROL, ctl);
	endtask : setup
	// Measures one whole carrier period between two period-end pulses
	task meas;
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (carrier_period_end !== 1'b1 && n < 400);
		per = 0;
		hic = 0;
		do begin
			@(posedge pclk);
			per++;
			if (carrier_out === 1'b1) hic++;
		end while (carrier_period_end !== 1'b1 && per < 400);
		if (n >= 400 || per >= 400) failures++;
	endtask : meas
	task wait_pin(input logic v);
		int n;
		n = 0;
		while (ir_out_pin !== v && n < 8) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, ir_out_pin}, {31'h0, v});
	endtask : wait_pin
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#(50 * 20000);
		failures++;
		results();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({31'h0, carrier_out}, 32'h1);
		chk({25'h0, mcs, ir_out_pin, pready, pslverr}, 32'h0);
		$display("reset test done");
		foreach (ROWS[k]) begin
			setup({2'h0, ROWS[k].hi}, {2'h0, ROWS[k].lo}, {25'h0, ROWS[k].halve, 6'h01});
			meas();
			i = ROWS[k].halve ? 2 : 1;
			chk(per, (ROWS[k].hi + ROWS[k].lo) * i);
			chk(hic, ROWS[k].hi * i);
		end
		$display("row test done");
		apb(1'b0, 8'h00, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		// Software must load nonzero counts first
		setup(8'h82, 8'h82, 32'h0);
		wait_pin(1'b1);
		apb(1'b0, ADDR_PRI_LOW, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h82);
		apb(1'b1, ADDR_PRI_LOW, 32'h02);
		wait_pin(1'b0);
		chk({16'h0, flashes}, 32'h1);
		apb(1'b1, ADDR_CONTROL, 32'h1);
		modulator_out <= 1'b1;
		wait_pin(1'b1);
		modulator_out <= 1'b0;
		wait_pin(1'b0);
		$display("latch test done");
		apb(1'b1, ADDR_CONTROL, 32'h3);
		// Carrier register lags the control write by one edge, period-end register by two
		repeat (2) @(posedge pclk);
		bad = 0;
		repeat (150) begin
			@(posedge pclk);
			if (carrier_out !== 1'b1 || carrier_period_end !== 1'b0) bad++;
		end
		chk(bad, 0);
		$display("baseband test done");
		apb(1'b1, ADDR_SEC_HIGH, 32'h05);
		apb(1'b1, ADDR_SEC_LOW, 32'h05);
		apb(1'b1, ADDR_CONTROL, 32'h5);
		meas();
		chk(per, 32'h4);
		chk({28'h0, mcs}, 32'h5);
		fsk_switch <= 1'b1;
		@(posedge pclk);
		fsk_switch <= 1'b0;
		meas();
		chk(per, 32'ha);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk({31'h0, rd[CTL_SEC_BIT]}, 32'h1);
		apb(1'b1, ADDR_CONTROL, 32'h1);
		meas();
		chk(per, 32'h4);
		$display("shift keying test done");
		setup(8'h83, 8'h82, 32'h0);
		wait_pin(1'b1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CONTROL, 32'h0);
		// Idle live carrier reads high in bit 5
		chk({24'h0, rd[6:0], ir_out_pin}, 32'h40);
		apb(1'b1, ADDR_CONTROL, 32'h1);
		meas();
		chk(per, 32'h5);
		$display("second reset test done");
		results();
	end
endmodule : ir_carrier_generator_tb
